// File: rtl/bmd_pkg.sv
// shared types and constants for the bus mode detect and reset sequencer
package bmd_pkg;

	// bus operating modes
	typedef enum logic [1:0] {MODE_PCI, MODE_X66, MODE_X100, MODE_X133} bmd_mode_e;

	// initialization pattern sampled at primary reset release
	typedef struct packed {
		logic devsel_n;
		logic stop_n;
		logic trdy_n;
	} bmd_init_s;

	// bus drive permissions
	typedef struct packed {
		logic upstreamOe;
		logic downstreamAdCbeLowOe;
		logic downstreamCtrlOe;
	} bmd_drive_s;

	// clock rate, 50 MHz
	localparam longint unsigned CLK_HZ = 64'h0000_0000_02fa_f080;
	localparam longint unsigned US_PER_S = 64'h0000_0000_000f_4240;

	// times in microseconds
	localparam longint unsigned PLL_LOCK_US = 64'h0000_0000_0000_0064;
	localparam longint unsigned CLK_STABLE_US = 64'h0000_0000_0000_0064;
	localparam longint unsigned CAP_CHARGE_US = 64'h0000_0000_0000_0050;
	localparam longint unsigned PROBE_SETTLE_US = 64'h0000_0000_0000_0001;

	// least waits, rounded up to whole cycles
	localparam longint unsigned PLL_LOCK_CYCLES =
		(PLL_LOCK_US * CLK_HZ + US_PER_S - 64'h1) / US_PER_S;
	localparam longint unsigned CLK_STABLE_CYCLES =
		(CLK_STABLE_US * CLK_HZ + US_PER_S - 64'h1) / US_PER_S;
	localparam longint unsigned CAP_CHARGE_CYCLES =
		(CAP_CHARGE_US * CLK_HZ + US_PER_S - 64'h1) / US_PER_S;
	localparam longint unsigned PROBE_SETTLE_CYCLES =
		(PROBE_SETTLE_US * CLK_HZ + US_PER_S - 64'h1) / US_PER_S;

	// timer width and short counts
	localparam int unsigned TMR_W = 16;
	localparam logic [15:0] CAP_CHARGE_LOAD = 16'(CAP_CHARGE_CYCLES);
	localparam logic [15:0] PROBE_SETTLE_LOAD = 16'(PROBE_SETTLE_CYCLES);
	localparam logic [15:0] UP_PCI_HOLD_CYCLES = 16'h0007;
	localparam logic [15:0] DN_TAIL_EDGES = 16'h000a;
	localparam logic [15:0] DN_PCI_HOLD_EDGES = 16'h0005;

	// primary mode decode, indexed by {devsel_n, stop_n, trdy_n}
	localparam bmd_mode_e INIT_DECODE [8] = '{
		MODE_PCI, MODE_X133, MODE_X100, MODE_X66,
		MODE_X133, MODE_X100, MODE_X66, MODE_PCI
	};

endpackage

// File: rtl/bmd_reset_top.sv
// bus mode detection, driver impedance choice and reset sequencing
`timescale 1ns/100ps
module bmd_reset_top
	import bmd_pkg::*;
#(
	parameter int unsigned PLL_LOCK_CYC = 32'(PLL_LOCK_CYCLES),
	parameter int unsigned CLK_STABLE_CYC = 32'(CLK_STABLE_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// primary bus pins
	input wire logic upstreamReset_n,
	input wire bmd_init_s upstreamInit,
	input wire logic upstreamImpedanceInvert,
	// secondary bus pins
	input wire logic downstreamClock,
	input wire logic downstreamClkStable,
	input wire logic downstreamCapabilitySense,
	input wire logic downstreamSpeedSelect,
	input wire logic downstreamImpedanceInvert,
	output logic downstreamStrongPullupEn,
	output logic downstreamReset_n,
	// secondary reset bit from bridge control
	input wire logic downstreamResetRequest,
	// primary status
	output bmd_mode_e upstreamMode,
	output logic upstreamPllBypass,
	output logic upstreamImpedance40,
	output logic upstreamLogicReset,
	output logic upstreamAccessEnable,
	// secondary status
	output bmd_mode_e downstreamMode,
	output logic downstreamPllBypass,
	output logic downstreamImpedance40,
	output logic downstreamLogicReset,
	// bus drive permissions
	output bmd_drive_s busDrive
);

	typedef enum {DN_HOLD, DN_STABLE_WAIT, DN_PROBE, DN_PULLUP, DN_SPEED,
		DN_WINDOW, DN_TAIL, DN_LOGIC, DN_RUN} bmd_dn_state_e;
	if (PLL_LOCK_CYC == 0 || PLL_LOCK_CYC > 32'h0000_ffff || CLK_STABLE_CYC == 0 ||
			CLK_STABLE_CYC > 32'h0000_ffff) begin : gChkTimer
		$error("PLL_LOCK_CYC and CLK_STABLE_CYC must fit the 16-bit timer");
	end
	// synchronised pins
	logic [9:0] pinRaw;
	logic [9:0] pinSync;
	logic upRstPinN;
	logic dnClkLvl;
	logic dnStable;
	logic dnCap;
	logic dnSpeed;
	logic upInv;
	logic dnInv;
	bmd_init_s initSync;
	assign pinRaw = {upstreamReset_n, upstreamInit, downstreamClock, downstreamClkStable,
		downstreamCapabilitySense, downstreamSpeedSelect, upstreamImpedanceInvert,
		downstreamImpedanceInvert};
	// primary reset and pattern share one synchroniser so they stay aligned
	bmd_sync #(.WIDTH(10)) uSync (
		.clk(clk),
		.rst(rst),
		.din(pinRaw),
		.q(pinSync)
	);
	assign upRstPinN = pinSync[9];
	assign initSync = pinSync[8:6];
	assign dnClkLvl = pinSync[5];
	assign dnStable = pinSync[4];
	assign dnCap = pinSync[3];
	assign dnSpeed = pinSync[2];
	assign upInv = pinSync[1];
	assign dnInv = pinSync[0];

	// primary side state
	logic upAsserted;
	logic upRstPrev;
	logic upRelease;
	bmd_mode_e upDecoded;
	logic [15:0] upLoad;
	logic upTimerExpired;
	logic next_upRstPrev;
	bmd_mode_e next_upstreamMode;
	logic next_upstreamPllBypass;
	logic next_upstreamImpedance40;
	logic next_upstreamLogicReset;
	logic next_upstreamAccessEnable;

	assign upAsserted = ~upRstPinN;
	assign upRelease = upRstPrev & ~upAsserted;
	assign upDecoded = INIT_DECODE[initSync];
	assign upLoad = (upDecoded == MODE_PCI) ? UP_PCI_HOLD_CYCLES : 16'(PLL_LOCK_CYC);

	bmd_timer #(.WIDTH(TMR_W)) uUpTimer (
		.clk(clk),
		.rst(rst),
		.start(upRelease),
		.clear(upAsserted),
		.tick(1'b1),
		.load(upLoad),
		.expired(upTimerExpired)
	);

	always_comb begin
		next_upRstPrev = upAsserted;
		next_upstreamMode = upstreamMode;
		next_upstreamPllBypass = upstreamPllBypass;
		next_upstreamImpedance40 = upstreamImpedance40;
		next_upstreamLogicReset = upstreamLogicReset;
		if (upAsserted) begin
			next_upstreamMode = MODE_PCI;
			next_upstreamPllBypass = 1'b1;
			next_upstreamImpedance40 = 1'b0;
			next_upstreamLogicReset = 1'b1;
		end else if (upRelease) begin
			next_upstreamMode = upDecoded;
			next_upstreamPllBypass = (upDecoded == MODE_PCI);
			next_upstreamImpedance40 = (upDecoded == MODE_X133) ^ upInv;
		end else if (upTimerExpired) begin
			next_upstreamLogicReset = 1'b0;
		end
		next_upstreamAccessEnable = ~next_upstreamLogicReset;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			upRstPrev <= 1'b1;
			upstreamMode <= MODE_PCI;
			upstreamPllBypass <= 1'b1;
			upstreamImpedance40 <= 1'b0;
			upstreamLogicReset <= 1'b1;
			upstreamAccessEnable <= 1'b0;
		end else begin
			upRstPrev <= next_upRstPrev;
			upstreamMode <= next_upstreamMode;
			upstreamPllBypass <= next_upstreamPllBypass;
			upstreamImpedance40 <= next_upstreamImpedance40;
			upstreamLogicReset <= next_upstreamLogicReset;
			upstreamAccessEnable <= next_upstreamAccessEnable;
		end
	end

	// secondary side state
	bmd_dn_state_e dnState;
	bmd_dn_state_e next_dnState;
	logic dnClkPrev;
	logic dnClkEdge;
	logic dnHoldReq;
	logic winStart;
	logic [15:0] winLoad;
	logic winExpired;
	logic stepStart;
	logic stepTick;
	logic [15:0] stepLoad;
	logic stepExpired;
	logic next_downstreamStrongPullupEn;
	logic next_downstreamReset_n;
	bmd_mode_e next_downstreamMode;
	logic next_downstreamPllBypass;
	logic next_downstreamImpedance40;
	logic next_downstreamLogicReset;
	bmd_drive_s next_busDrive;

	// secondary clock edges counted on the filtered level
	assign dnClkEdge = dnClkLvl & ~dnClkPrev;
	// primary reset or the secondary reset bit restarts the secondary sequence
	assign dnHoldReq = upAsserted | downstreamResetRequest;
	assign stepTick = (dnState == DN_TAIL || dnState == DN_LOGIC) ? dnClkEdge : 1'b1;

	bmd_timer #(.WIDTH(TMR_W)) uWinTimer (
		.clk(clk),
		.rst(rst),
		.start(winStart),
		.clear(dnHoldReq),
		.tick(1'b1),
		.load(winLoad),
		.expired(winExpired)
	);
	bmd_timer #(.WIDTH(TMR_W)) uStepTimer (
		.clk(clk),
		.rst(rst),
		.start(stepStart),
		.clear(dnHoldReq),
		.tick(stepTick),
		.load(stepLoad),
		.expired(stepExpired)
	);

	always_comb begin
		next_dnState = dnState;
		next_downstreamStrongPullupEn = downstreamStrongPullupEn;
		next_downstreamReset_n = downstreamReset_n;
		next_downstreamMode = downstreamMode;
		next_downstreamPllBypass = downstreamPllBypass;
		next_downstreamImpedance40 = downstreamImpedance40;
		next_downstreamLogicReset = downstreamLogicReset;
		winStart = 1'b0;
		winLoad = 16'(CLK_STABLE_CYC);
		stepStart = 1'b0;
		stepLoad = PROBE_SETTLE_LOAD;
		if (dnHoldReq) begin
			next_dnState = DN_HOLD;
			next_downstreamStrongPullupEn = 1'b0;
			next_downstreamReset_n = 1'b0;
			next_downstreamLogicReset = 1'b1;
			next_downstreamPllBypass = 1'b1;
			if (upAsserted) begin
				next_downstreamMode = MODE_PCI;
				next_downstreamImpedance40 = 1'b0;
			end
		end else begin
			unique case (dnState)
				DN_HOLD: next_dnState = DN_STABLE_WAIT;
				DN_STABLE_WAIT: begin
					// clock-stable is taken once and not watched again
					if (dnStable) begin
						winStart = 1'b1;
						stepStart = 1'b1;
						next_downstreamStrongPullupEn = 1'b0;
						next_dnState = DN_PROBE;
					end
				end
				DN_PROBE: begin
					if (stepExpired) begin
						if (dnCap) begin
							next_dnState = DN_SPEED;
						end else begin
							next_downstreamStrongPullupEn = 1'b1;
							stepStart = 1'b1;
							stepLoad = CAP_CHARGE_LOAD;
							next_dnState = DN_PULLUP;
						end
					end
				end
				DN_PULLUP: begin
					if (stepExpired) begin
						next_downstreamMode = dnCap ? MODE_X66 : MODE_PCI;
						next_downstreamPllBypass = ~dnCap;
						next_downstreamStrongPullupEn = 1'b0;
						next_dnState = DN_WINDOW;
					end
				end
				DN_SPEED: begin
					next_downstreamMode = dnSpeed ? MODE_X100 : MODE_X133;
					next_downstreamPllBypass = 1'b0;
					next_dnState = DN_WINDOW;
				end
				DN_WINDOW: begin
					if (winExpired) begin
						stepStart = 1'b1;
						stepLoad = 16'(DN_TAIL_EDGES + 16'h0001);
						next_dnState = DN_TAIL;
					end
				end
				DN_TAIL: begin
					if (stepExpired) begin
						next_downstreamReset_n = 1'b1;
						next_downstreamImpedance40 =
							(downstreamMode == MODE_X133) ^ dnInv;
						if (downstreamMode == MODE_PCI) begin
							stepStart = 1'b1;
							stepLoad = DN_PCI_HOLD_EDGES;
						end else begin
							winStart = 1'b1;
							winLoad = 16'(PLL_LOCK_CYC);
						end
						next_dnState = DN_LOGIC;
					end
				end
				DN_LOGIC: begin
					// release lines up with a secondary clock edge in PCI mode; other modes wait on the PLL_LOCK_CYC window timer
					if ((downstreamMode == MODE_PCI) ? stepExpired : winExpired) begin
						next_downstreamLogicReset = 1'b0;
						next_dnState = DN_RUN;
					end
				end
				DN_RUN: next_dnState = DN_RUN;
			endcase
		end
		next_busDrive.upstreamOe = ~next_upstreamLogicReset;
		next_busDrive.downstreamAdCbeLowOe = ~next_downstreamReset_n;
		next_busDrive.downstreamCtrlOe = next_downstreamReset_n;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dnState <= DN_HOLD;
			dnClkPrev <= 1'b0;
			downstreamStrongPullupEn <= 1'b0;
			downstreamReset_n <= 1'b0;
			downstreamMode <= MODE_PCI;
			downstreamPllBypass <= 1'b1;
			downstreamImpedance40 <= 1'b0;
			downstreamLogicReset <= 1'b1;
			busDrive <= '{upstreamOe: 1'b0, downstreamAdCbeLowOe: 1'b1, downstreamCtrlOe: 1'b0};
		end else begin
			dnState <= next_dnState;
			dnClkPrev <= dnClkLvl;
			downstreamStrongPullupEn <= next_downstreamStrongPullupEn;
			downstreamReset_n <= next_downstreamReset_n;
			downstreamMode <= next_downstreamMode;
			downstreamPllBypass <= next_downstreamPllBypass;
			downstreamImpedance40 <= next_downstreamImpedance40;
			downstreamLogicReset <= next_downstreamLogicReset;
			busDrive <= next_busDrive;
		end
	end

endmodule

// File: rtl/bmd_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module bmd_sync
	import bmd_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// asynchronous inputs
	input wire logic [WIDTH-1:0] din,
	// filtered levels
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_q;

	if (WIDTH == 0) begin : gChk
		$error("bmd_sync needs at least one bit");
	end

	// a bit takes a new value once stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

endmodule

// File: rtl/bmd_timer.sv
// loadable down counter with tick enable and expiry flag
`timescale 1ns/100ps
module bmd_timer
	import bmd_pkg::*;
#(
	parameter int unsigned WIDTH = TMR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic start,
	input wire logic clear,
	input wire logic tick,
	input wire logic [WIDTH-1:0] load,
	// status
	output logic expired
);

	logic [WIDTH-1:0] count;
	logic armed;
	logic [WIDTH-1:0] next_count;
	logic next_armed;

	if (WIDTH < 4) begin : gChk
		$error("bmd_timer width too small");
	end

	always_comb begin
		next_count = count;
		next_armed = armed;
		if (clear) begin
			next_count = '0;
			next_armed = 1'b0;
		end else if (start) begin
			next_count = load;
			next_armed = 1'b1;
		end else if (tick && count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
			armed <= 1'b0;
		end else begin
			count <= next_count;
			armed <= next_armed;
		end
	end

	assign expired = armed && (count == '0);

endmodule

// File: tb/bmd_far_side.sv
// secondary bus devices: capability strap, speed select, clock and clock-stable source
`timescale 1ns/100ps
module bmd_far_side (
	// setup from bench
	input wire logic [1:0] devKind,
	input wire logic sel100,
	input wire logic stableReq,
	// pins
	input wire logic strongPullupEn,
	output logic capSense,
	output logic speedSelect,
	output logic secClk,
	output logic clkStable
);
	initial begin
		secClk = 1'b0;
	end
	// free running 2 MHz clock, steady at its frequency
	always #250 secClk = ~secClk;
	// 0 tied low, 1 weak pull-down only, else fully capable
	always_comb begin
		case (devKind)
			2'h0: capSense = 1'b0;
			2'h1: capSense = strongPullupEn;
			default: capSense = 1'b1;
		endcase
	end
	assign speedSelect = sel100;
	// one rise per reset, when the bench says
	assign clkStable = stableReq;
endmodule

// File: tb/bmd_reset_props.sv
// assertions on the mode detect and reset sequencer ports
`timescale 1ns/100ps
module bmd_reset_props
	import bmd_pkg::*;
#(
	parameter int unsigned PLL_LOCK_CYC = 5000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic upstreamReset_n,
	input wire logic upstreamImpedanceInvert,
	input wire logic downstreamClkStable,
	input wire logic downstreamCapabilitySense,
	input wire logic downstreamImpedanceInvert,
	input wire logic downstreamStrongPullupEn,
	input wire logic downstreamReset_n,
	// status
	input wire bmd_mode_e upstreamMode,
	input wire logic upstreamPllBypass,
	input wire logic upstreamImpedance40,
	input wire logic upstreamLogicReset,
	input wire logic upstreamAccessEnable,
	input wire bmd_mode_e downstreamMode,
	input wire logic downstreamPllBypass,
	input wire logic downstreamImpedance40,
	input wire bmd_drive_s busDrive
);
	logic [15:0] lowCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// cycles since primary reset release while accesses are refused
	always_ff @(posedge clk) begin
		if (rst || !upstreamReset_n || upstreamAccessEnable) begin
			lowCnt <= 16'h0000;
		end else if (lowCnt != 16'hffff) begin
			lowCnt <= lowCnt + 16'h0001;
		end
	end
	AST_UP_RST: assert property (!upstreamReset_n [*6] |-> upstreamLogicReset &&
		!busDrive.upstreamOe && !downstreamReset_n) else $error("primary reset not applied");
	AST_UP_HOLD: assert property ($rose(upstreamReset_n) |-> upstreamLogicReset [*8])
		else $error("primary logic reset released early");
	AST_UP_PLL: assert property ($rose(upstreamAccessEnable) && upstreamMode != MODE_PCI
		|-> lowCnt >= PLL_LOCK_CYC) else $error("access enabled before lock time");
	AST_ACC: assert property (upstreamAccessEnable != upstreamLogicReset)
		else $error("access enable disagrees with logic reset");
	AST_UP_IMP: assert property ($fell(upstreamLogicReset) |-> upstreamImpedance40 ==
		((upstreamMode == MODE_X133) ^ upstreamImpedanceInvert) &&
		upstreamPllBypass == (upstreamMode == MODE_PCI)) else $error("primary impedance wrong");
	AST_UP_KEEP: assert property (!upstreamLogicReset && !$past(upstreamLogicReset)
		|-> $stable(upstreamImpedance40) && $stable(upstreamMode)) else $error("primary setup moved");
	AST_DN_IMP: assert property ($rose(downstreamReset_n) |-> downstreamImpedance40 ==
		((downstreamMode == MODE_X133) ^ downstreamImpedanceInvert) &&
		downstreamPllBypass == (downstreamMode == MODE_PCI)) else $error("secondary impedance wrong");
	AST_DN_KEEP: assert property (downstreamReset_n && $past(downstreamReset_n)
		|-> $stable(downstreamImpedance40)) else $error("secondary impedance moved");
	AST_DRIVE: assert property (busDrive.downstreamAdCbeLowOe != downstreamReset_n &&
		busDrive.downstreamCtrlOe == downstreamReset_n) else $error("secondary drive wrong");
	AST_PU_WAIT: assert property (!downstreamClkStable [*5] |-> !downstreamStrongPullupEn)
		else $error("pull-up on before clock stable");
	AST_PU_CAP: assert property ($rose(downstreamStrongPullupEn) |->
		!$past(downstreamCapabilitySense)) else $error("pull-up on after high sample");
endmodule

// File: tb/bmd_reset_top_tb_top.sv
// self-checking bench for the mode detect and reset sequencer
`timescale 1ns/100ps
module bmd_reset_top_tb_top
	import bmd_pkg::*;
;
	localparam int unsigned PLL = 300;
	localparam int unsigned CST = 300;
	logic clk, rst, upRstN, upInv, dnInv, dnReq, sel100, stableReq;
	logic pullupEn, capSense, speedSel, secClk, clkStable;
	logic [1:0] devKind;
	bmd_init_s initPat;
	bmd_mode_e upMode, dnMode;
	logic upBypass, upImp, upLogicRst, upAcc, dnRstN, dnBypass, dnImp, dnLogicRst;
	bmd_drive_s drive;
	int nFail, nTests, cycles, n;

	bmd_reset_top #(.PLL_LOCK_CYC(PLL), .CLK_STABLE_CYC(CST)) dut_u (.clk, .rst,
		.upstreamReset_n(upRstN), .upstreamInit(initPat), .upstreamImpedanceInvert(upInv),
		.downstreamClock(secClk), .downstreamClkStable(clkStable),
		.downstreamCapabilitySense(capSense), .downstreamSpeedSelect(speedSel),
		.downstreamImpedanceInvert(dnInv), .downstreamStrongPullupEn(pullupEn),
		.downstreamReset_n(dnRstN), .downstreamResetRequest(dnReq), .upstreamMode(upMode),
		.upstreamPllBypass(upBypass), .upstreamImpedance40(upImp), .upstreamLogicReset(upLogicRst),
		.upstreamAccessEnable(upAcc), .downstreamMode(dnMode), .downstreamPllBypass(dnBypass),
		.downstreamImpedance40(dnImp), .downstreamLogicReset(dnLogicRst), .busDrive(drive));
	bmd_far_side far_u (.devKind, .sel100, .stableReq, .strongPullupEn(pullupEn), .capSense,
		.speedSelect(speedSel), .secClk, .clkStable);

	always #10 clk = ~clk;

	task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string msg);
		nTests++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic stopTest();
		$display("checks %0d, mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// 0 access enable, 1 secondary bus reset, 2 secondary logic reset
	task automatic waitFor(input int sel, input logic lvl, output int cnt);
		logic s;
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
			s = (sel == 0) ? upAcc : (sel == 1) ? dnRstN : dnLogicRst;
		end while (s !== lvl && cnt < 20000);
		if (s !== lvl) check(3'(s), 3'(lvl), "wait limit reached");
	endtask

	task automatic boot(input logic [2:0] pat, input bmd_mode_e upExp, input logic ui,
			input logic [1:0] kind, input logic sel, input logic di, input bmd_mode_e dnExp);
		int k;
		@(negedge clk);
		upRstN = 1'b0;
		repeat (8) @(negedge clk);
		check(3'({upLogicRst, dnRstN}), 3'h2, "resets not held");
		check(drive, 3'h2, "drive in reset");
		check(3'(upMode), 3'(MODE_PCI), "mode not defaulted");
		initPat = pat;
		upInv = ui;
		devKind = kind;
		sel100 = sel;
		dnInv = di;
		stableReq = 1'b0;
		repeat (6) @(negedge clk);
		upRstN = 1'b1;
		waitFor(0, 1'b1, k);
		check(3'(upExp == MODE_PCI ? (k >= 9 && k <= 14) :
			(k >= PLL + 2 && k <= PLL + 7)), 3'h1, "access hold");
		check(3'(upMode), 3'(upExp), "primary mode");
		check(3'({upImp, upBypass}), 3'({(upExp == MODE_X133) ^ ui, upExp == MODE_PCI}),
			"primary impedance");
		repeat (30) @(negedge clk);
		check(3'({pullupEn, dnRstN}), 3'h0, "detect before stable");
		stableReq = 1'b1;
		waitFor(1, 1'b1, k);
		check(3'(k >= CST + 250), 3'h1, "secondary reset early");
		check(3'(dnMode), 3'(dnExp), "secondary mode");
		check(3'({dnImp, dnBypass}), 3'({(dnExp == MODE_X133) ^ di, dnExp == MODE_PCI}),
			"secondary impedance");
		check(drive, 3'h5, "drive running");
		waitFor(2, 1'b0, k);
		check(3'(dnExp == MODE_PCI ? (k >= 95 && k <= 135) :
			(k >= PLL - 2 && k <= PLL + 6)), 3'h1, "secondary logic hold");
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			nFail++;
			stopTest();
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		upRstN = 1'b0;
		initPat = '0;
		upInv = 1'b0;
		dnInv = 1'b0;
		dnReq = 1'b0;
		devKind = 2'h0;
		sel100 = 1'b0;
		stableReq = 1'b0;
		nFail = 0;
		nTests = 0;
		cycles = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		boot(3'b000, MODE_PCI, 1'b0, 2'h0, 1'b0, 1'b0, MODE_PCI);
		boot(3'b001, MODE_X133, 1'b0, 2'h1, 1'b0, 1'b0, MODE_X66);
		boot(3'b010, MODE_X100, 1'b1, 2'h2, 1'b1, 1'b0, MODE_X100);
		boot(3'b011, MODE_X66, 1'b0, 2'h2, 1'b0, 1'b1, MODE_X133);
		boot(3'b100, MODE_X133, 1'b1, 2'h2, 1'b0, 1'b0, MODE_X133);
		boot(3'b101, MODE_X100, 1'b0, 2'h0, 1'b0, 1'b1, MODE_PCI);
		boot(3'b110, MODE_X66, 1'b0, 2'h1, 1'b1, 1'b0, MODE_X66);
		boot(3'b111, MODE_PCI, 1'b1, 2'h2, 1'b1, 1'b0, MODE_X100);
		// invert pin while running, then secondary reset by request
		dnInv = 1'b1;
		repeat (50) @(negedge clk);
		check(3'(dnImp), 3'h0, "impedance moved while running");
		dnReq = 1'b1;
		repeat (4) @(negedge clk);
		check(3'({dnRstN, upAcc}), 3'h1, "secondary reset request");
		dnReq = 1'b0;
		waitFor(1, 1'b1, n);
		check(3'({dnImp, dnMode}), 3'({1'b1, MODE_X100}), "impedance after reset");
		stopTest();
	end
endmodule

bind bmd_reset_top bmd_reset_props #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) props_u (.clk, .rst,
	.upstreamReset_n, .upstreamImpedanceInvert, .downstreamClkStable, .downstreamCapabilitySense,
	.downstreamImpedanceInvert, .downstreamStrongPullupEn, .downstreamReset_n, .upstreamMode,
	.upstreamPllBypass, .upstreamImpedance40, .upstreamLogicReset, .upstreamAccessEnable,
	.downstreamMode, .downstreamPllBypass, .downstreamImpedance40, .busDrive);
